// ### her_pkg.sv
// package for the host event reporter: constants, states and carriers
package her_pkg;

   localparam int NAXES = 4;
   localparam int AW = 8;
   localparam int DW = 32;

   // register word addresses
   localparam logic [AW-1:0] ADDR_STATUS = 8'h00;
   localparam logic [AW-1:0] ADDR_MASK = 8'h04;
   localparam logic [AW-1:0] ADDR_CMD = 8'h08;
   localparam logic [AW-1:0] ADDR_ENABLE = 8'h0C;
   localparam logic [AW-1:0] ADDR_MOTION = 8'h10;
   localparam logic [AW-1:0] ADDR_ID = 8'h14;

   // status bit positions; bit 6 is the conflicting-commands error
   localparam int ST_RESET_DONE = 0;
   localparam int ST_FERR_HALT = 1;
   localparam int ST_INDEX = 2;
   localparam int ST_BRKPT = 3;
   localparam int ST_MDONE = 4;
   localparam int ST_EXTIN = 5;
   localparam int ST_CONFLICT = 6;
   localparam int ST_W = 7;

   // enable register bit positions
   localparam int EN_FERR_HALT = 0;
   localparam int EN_INDEX = 1;
   localparam int EN_BRKPT = 2;
   localparam int EN_MDONE = 3;
   localparam int EN_EXTIN = 4;
   localparam int EN_W = 5;

   // command register layout: [3:0] axis mask, [6:4] opcode
   localparam int CMD_AXIS_LSB = 0;
   localparam int CMD_OP_LSB = 4;
   localparam logic [2:0] OP_POINT_MOVE = 3'h1;
   localparam logic [2:0] OP_VELOCITY = 3'h2;
   localparam logic [2:0] OP_CONTOUR_START = 3'h3;
   localparam logic [2:0] OP_STOP = 3'h4;
   localparam logic [2:0] OP_RESET = 3'h5;

   // identity word, value arbitrary
   localparam logic [DW-1:0] ID_VALUE = 32'h0000A5C3;

   // shared memory size: 2K bytes as 512 words
   localparam int MEM_WORDS = 512;

   // reset sequence length, one cycle per memory word
   localparam int RESET_CYCLES = MEM_WORDS;

   typedef enum logic [1:0] {S_CLEAR, S_DONE, S_RUN} her_state_e;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } her_bus_s;

   typedef struct packed {
      logic ferr_halt;
      logic index;
      logic brkpt;
      logic mdone;
      logic extin;
   } her_evt_s;

endpackage

// ### her_top.sv
// host event reporter: reset sequence, conflict checker, sticky interrupts
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
module her_top
   import her_pkg::*;
#(
   parameter int N_AXES = NAXES
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire her_bus_s bus,
   output logic [DW-1:0] rdata,
   input wire her_evt_s evt,
   input wire logic [N_AXES-1:0] axis_motion_done,
   output logic [N_AXES-1:0] contour_axes,
   output logic [N_AXES-1:0] point_axes,
   output logic [N_AXES-1:0] cmd_accept,
   output logic busy,
   output logic irq
);

   her_state_e state_r, state_nxt;
   logic [9:0] clr_cnt_r;
   logic [ST_W-1:0] status_r;
   logic [ST_W-1:0] mask_r;
   logic [EN_W-1:0] enable_r;
   logic [N_AXES-1:0] contour_r;
   logic [N_AXES-1:0] point_r;
   logic [N_AXES-1:0] accept_r;
   logic [DW-1:0] rdata_r;
   logic [DW-1:0] shared_dual_port_memory [MEM_WORDS];

   // bus decode
   wire running = (state_r == S_RUN);
   wire wr_status = running && bus.wr && bus.addr == ADDR_STATUS;
   wire wr_mask = running && bus.wr && bus.addr == ADDR_MASK;
   wire wr_cmd = running && bus.wr && bus.addr == ADDR_CMD;
   wire wr_enable = running && bus.wr && bus.addr == ADDR_ENABLE;
   wire mem_sel = bus.addr[AW-1];
   wire [2:0] cmd_op = bus.wdata[CMD_OP_LSB +: 3];
   wire [N_AXES-1:0] cmd_axes = bus.wdata[CMD_AXIS_LSB +: N_AXES];
   // the reset command also restarts the whole sequence
   wire soft_reset = wr_cmd && cmd_op == OP_RESET;

   wire is_point = wr_cmd && (cmd_op == OP_POINT_MOVE || cmd_op == OP_VELOCITY);
   wire is_contour = wr_cmd && cmd_op == OP_CONTOUR_START;
   wire is_stop = wr_cmd && cmd_op == OP_STOP;
   wire conflict = (is_point && |(cmd_axes & contour_r))
      || (is_contour && |(cmd_axes & point_r));

   wire point_go = is_point && !conflict;
   wire contour_go = is_contour && !conflict;

   // external events gated by their enables; conflict and reset done set ungated
   wire [ST_W-1:0] ev_set;
   assign ev_set[ST_FERR_HALT] = running && evt.ferr_halt && enable_r[EN_FERR_HALT];
   assign ev_set[ST_INDEX] = running && evt.index && enable_r[EN_INDEX];
   assign ev_set[ST_BRKPT] = running && evt.brkpt && enable_r[EN_BRKPT];
   assign ev_set[ST_MDONE] = running && evt.mdone && enable_r[EN_MDONE];
   assign ev_set[ST_EXTIN] = running && evt.extin && enable_r[EN_EXTIN];
   assign ev_set[ST_CONFLICT] = conflict;
   assign ev_set[ST_RESET_DONE] = (state_r == S_DONE);

   // sequencer: clear memory, then announce, then run
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         S_CLEAR: if (clr_cnt_r == 10'(RESET_CYCLES - 1)) state_nxt = S_DONE;
         S_DONE: state_nxt = S_RUN;
         S_RUN: if (soft_reset) state_nxt = S_CLEAR;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state_r <= S_CLEAR;
      else
         state_r <= state_nxt;
   end

   // clear counter walks every memory word
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         clr_cnt_r <= 10'h000;
      else if (state_r != S_CLEAR)
         clr_cnt_r <= 10'h000;
      else
         clr_cnt_r <= clr_cnt_r + 10'h001;
   end

   always_ff @(posedge mclk)
   begin
      if (state_r == S_CLEAR)
         shared_dual_port_memory[clr_cnt_r[8:0]] <= '0;
      else if (running && bus.wr && mem_sel)
         shared_dual_port_memory[bus.addr[6:0]] <= bus.wdata;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         status_r <= '0;
      else if (state_r == S_CLEAR)
         status_r <= '0;
      else
         status_r <= (status_r & ~(wr_status ? bus.wdata[ST_W-1:0] : '0)) | ev_set;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mask_r <= '0;
         enable_r <= '0;
      end
      else if (state_r == S_CLEAR)
      begin
         mask_r <= '0;
         enable_r <= '0;
      end
      else
      begin
         if (wr_mask)
            mask_r <= bus.wdata[ST_W-1:0];
         if (wr_enable)
            enable_r <= bus.wdata[EN_W-1:0];
      end
   end

   // motion ownership per axis; done or stop frees the axis
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         contour_r <= '0;
         point_r <= '0;
         accept_r <= '0;
      end
      else if (state_r == S_CLEAR)
      begin
         contour_r <= '0;
         point_r <= '0;
         accept_r <= '0;
      end
      else
      begin
         contour_r <= (contour_r & ~axis_motion_done & ~(is_stop ? cmd_axes : '0))
            | (contour_go ? cmd_axes : '0);
         point_r <= (point_r & ~axis_motion_done & ~(is_stop ? cmd_axes : '0))
            | (point_go ? cmd_axes : '0);
         accept_r <= (point_go || contour_go) ? cmd_axes : '0;
      end
   end

   // read mux, one cycle later
   logic [DW-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      if (mem_sel)
         rd_mux = shared_dual_port_memory[bus.addr[6:0]];
      else
         case (bus.addr)
            ADDR_STATUS: rd_mux = DW'(status_r);
            ADDR_MASK: rd_mux = DW'(mask_r);
            ADDR_ENABLE: rd_mux = DW'(enable_r);
            ADDR_MOTION: rd_mux = DW'({point_r, contour_r});
            ADDR_ID: rd_mux = ID_VALUE;
            default: rd_mux = '0;
         endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rdata_r <= '0;
      else
         rdata_r <= bus.rd ? rd_mux : '0;
   end

   assign rdata = rdata_r;
   assign contour_axes = contour_r;
   assign point_axes = point_r;
   assign cmd_accept = accept_r;
   assign busy = !running;
   assign irq = |(status_r & mask_r) || status_r[ST_RESET_DONE];

   // assertions
   // conflict sets bit
   // irq only follows the flag when its mask bit lets it through
   conflict_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
      conflict |=> status_r[ST_CONFLICT] && (irq || !mask_r[ST_CONFLICT]))
      else $error("conflict did not set status bit 6");
   conflict_drop_a: assert property (@(posedge mclk) disable iff (!rst_b)
      conflict |=> cmd_accept == '0)
      else $error("conflicting command was accepted");
   point_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
      is_point && |(cmd_axes & contour_r) |=> status_r[ST_CONFLICT])
      else $error("point command on contouring axis not flagged");
   contour_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
      is_contour && |(cmd_axes & point_r) |=> $stable(contour_r) || axis_motion_done != '0)
      else $error("contour start on busy axis changed contour set");
   reset_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
      state_r == S_DONE |=> status_r[ST_RESET_DONE] && irq)
      else $error("reset finished not flagged");
   halt_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      running && !status_r[ST_FERR_HALT] && !enable_r[EN_FERR_HALT] |=> !status_r[ST_FERR_HALT])
      else $error("halt flag set while disabled");
   index_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      running && !status_r[ST_INDEX] && !enable_r[EN_INDEX] |=> !status_r[ST_INDEX])
      else $error("index flag set while disabled");
   mdone_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      running && !status_r[ST_MDONE] && !enable_r[EN_MDONE] |=> !status_r[ST_MDONE])
      else $error("motion complete flag set while disabled");
   sticky_bits_a: assert property (@(posedge mclk) disable iff (!rst_b)
      running && !soft_reset && !wr_status |=> (status_r & $past(status_r)) == $past(status_r))
      else $error("status bit dropped without host clear");
   clear_phase_a: assert property (@(posedge mclk) disable iff (!rst_b)
      soft_reset |=> busy [*8])
      else $error("reset command did not start clear sequence");

   point_start_c: cover property (@(posedge mclk) disable iff (!rst_b) point_go);
   contour_start_c: cover property (@(posedge mclk) disable iff (!rst_b) contour_go);
   conflict_seen_c: cover property (@(posedge mclk) disable iff (!rst_b) conflict);
   soft_reset_c: cover property (@(posedge mclk) disable iff (!rst_b) soft_reset);

endmodule

// ### her_host_model.sv
// host-side model: register port driver and reset-finished handshake
`timescale 1ns/100ps
module her_host_model
   import her_pkg::*;
(
   input wire logic mclk,
   input wire logic busy,
   input wire logic irq,
   input wire logic [DW-1:0] rdata,
   output her_bus_s bus
);
   initial bus = '0;

   // one-cycle write, released on the edge that takes it
   task automatic put(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
      #1;
   endtask

   // one-cycle read; data only stands in the next cycle
   task automatic get(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
      #1;
      d = rdata;
   endtask

   task automatic boot(output logic [DW-1:0] st);
      int n;
      n = 0;
      // bounded, a dead reset must not hang the host
      while ((busy !== 1'b0 || irq !== 1'b1) && n < 2000)
      begin
         // look past the edge so busy and irq have settled
         @(posedge mclk);
         #1;
         n++;
      end
      get(ADDR_STATUS, st);
      put(ADDR_STATUS, 32'h00000001 << ST_RESET_DONE);
   endtask
endmodule

// ### tb_her_top.sv
// self-checking bench for the host event reporter
`timescale 1ns/100ps
module tb_her_top
   import her_pkg::*;
();
   logic mclk;
   logic rst_b;
   her_bus_s bus;
   logic [DW-1:0] rdata;
   her_evt_s evt;
   logic [NAXES-1:0] axis_motion_done;
   logic [NAXES-1:0] contour_axes;
   logic [NAXES-1:0] point_axes;
   logic [NAXES-1:0] cmd_accept;
   logic busy;
   logic irq;
   logic [DW-1:0] st;
   int bad_count;
   int check_count;

   // 200 MHz clock
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   her_top #(.N_AXES(NAXES)) DUT (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
      .evt(evt), .axis_motion_done(axis_motion_done), .contour_axes(contour_axes),
      .point_axes(point_axes), .cmd_accept(cmd_accept), .busy(busy), .irq(irq));

   her_host_model host (.mclk(mclk), .busy(busy), .irq(irq), .rdata(rdata), .bus(bus));

   // compare and count
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      logic [DW-1:0] d;
      host.get(a, d);
      chk(d, exp);
   endtask

   // command write, accept pulse seen in the following cycle
   task automatic cmd(input logic [2:0] op, input logic [3:0] ax, input logic [3:0] acc);
      host.put(ADDR_CMD, {25'h0000000, op, ax});
      chk({28'h0000000, cmd_accept}, {28'h0000000, acc});
   endtask

   // single-cycle event pulse, then settle
   task automatic fire(input her_evt_s e);
      @(posedge mclk);
      evt <= e;
      @(posedge mclk);
      evt <= '0;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // watchdog, run needs about 1200 cycles
   initial
   begin
      #40000;
      bad_count++;
      print_verdict();
   end

   // main sequence
   initial
   begin
      rst_b = 1'b0;
      evt = '0;
      axis_motion_done = 4'h0;
      bad_count = 0;
      check_count = 0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chk(busy, 1'b1);
      host.boot(st);
      chk(st, 32'h00000001);
      chk(irq, 1'b0);
      host.put(ADDR_ENABLE, 32'h0000001F);
      host.put(ADDR_MASK, 32'h0000007F);
      host.put(8'h80, 32'h12345678);
      rchk(8'h80, 32'h12345678);
      host.put(ADDR_CMD, {25'h0000000, OP_RESET, 4'h0});
      repeat (2) @(posedge mclk);
      #1;
      chk(busy, 1'b1);
      host.boot(st);
      chk(st, 32'h00000001);
      rchk(8'h80, 32'h00000000);
      rchk(ADDR_ENABLE, 32'h00000000);
      rchk(ADDR_MASK, 32'h00000000);
      // events with every enable off leave no trace
      for (int i = 0; i < EN_W; i++)
      begin
         fire(her_evt_s'(5'h10 >> i));
         rchk(ADDR_STATUS, 32'h00000000);
      end
      // one enable at a time; earlier bits must stay set
      for (int i = 0; i < EN_W; i++)
      begin
         host.put(ADDR_ENABLE, 32'h00000001 << i);
         fire(her_evt_s'(5'h10 >> i));
         rchk(ADDR_STATUS, (32'h00000004 << i) - 32'h00000002);
      end
      chk(irq, 1'b0);
      host.put(ADDR_MASK, 32'h00000004);
      chk(irq, 1'b1);
      host.put(ADDR_STATUS, 32'h00000004);
      chk(irq, 1'b0);
      rchk(ADDR_STATUS, 32'h0000003A);
      host.put(ADDR_STATUS, 32'h0000007F);
      // conflicts in both directions
      cmd(OP_CONTOUR_START, 4'h1, 4'h1);
      cmd(OP_POINT_MOVE, 4'h1, 4'h0);
      rchk(ADDR_STATUS, 32'h00000040);
      host.put(ADDR_STATUS, 32'h00000040);
      cmd(OP_VELOCITY, 4'h1, 4'h0);
      rchk(ADDR_STATUS, 32'h00000040);
      host.put(ADDR_STATUS, 32'h00000040);
      cmd(OP_POINT_MOVE, 4'h2, 4'h2);
      rchk(ADDR_STATUS, 32'h00000000);
      cmd(OP_CONTOUR_START, 4'h6, 4'h0);
      rchk(ADDR_MOTION, 32'h00000021);
      host.put(ADDR_MASK, 32'h00000040);
      chk(irq, 1'b1);
      rchk(ADDR_STATUS, 32'h00000040);
      // stop and motion done free axes for the other kind of motion
      cmd(OP_STOP, 4'h1, 4'h0);
      chk({28'h0000000, contour_axes}, 32'h00000000);
      cmd(OP_POINT_MOVE, 4'h1, 4'h1);
      chk({28'h0000000, point_axes}, 32'h00000003);
      @(posedge mclk);
      axis_motion_done <= 4'h3;
      @(posedge mclk);
      axis_motion_done <= 4'h0;
      #1;
      chk({28'h0000000, point_axes}, 32'h00000000);
      cmd(OP_CONTOUR_START, 4'h6, 4'h6);
      chk({28'h0000000, contour_axes}, 32'h00000006);
      print_verdict();
   end
endmodule
